// >>> hw/uft_pkg.sv
// Purpose: Shared constants and types for the serial frame transmitter
// Assumes: 8-bit register port, 20 MHz system clock
// Notes:   Offsets are register indices on the plain register port
package uft_pkg;
   // ==========================================================
   // Register offsets
   localparam logic [3:0] UFT_ADDR_DATA   = 4'h0; // tx_data_buffer
   localparam logic [3:0] UFT_ADDR_STAT   = 4'h1; // status_a_reg
   localparam logic [3:0] UFT_ADDR_CTLB   = 4'h2; // control_b_reg
   localparam logic [3:0] UFT_ADDR_CTLC   = 4'h3; // frame format
   localparam logic [3:0] UFT_ADDR_BAUDL  = 4'h4;
   localparam logic [3:0] UFT_ADDR_BAUDH  = 4'h5;
   localparam logic [3:0] UFT_ADDR_IRQST  = 4'h6; // read-only sticky
   localparam logic [3:0] UFT_ADDR_IRQCLR = 4'h7; // write-only clear
   localparam logic [3:0] UFT_ADDR_IRQEN  = 4'h8;
   // ==========================================================
   // Field positions
   localparam int UFT_ST_EMPTY  = 0; // buffer empty
   localparam int UFT_ST_DONE   = 1; // tx_complete_flag
   localparam int UFT_ST_BUSY   = 2; // shift register active
   localparam int UFT_CB_TXEN   = 0;
   localparam int UFT_CB_NINTH  = 1; // tx_ninth_bit
   localparam int UFT_CB_SIZE   = 2; // 3-bit character size code
   localparam int UFT_CC_PAR    = 0; // 2-bit parity_mode_select
   localparam int UFT_CC_STOP2  = 2;
   localparam int UFT_CC_DBL    = 3; // double_speed_select
   localparam int UFT_CC_SYNC   = 4;
   localparam int UFT_IRQ_EMPTY = 0;
   localparam int UFT_IRQ_DONE  = 1;
   // ==========================================================
   // Reset values and encodings
   localparam logic [7:0]  UFT_CTLB_RST  = 8'h0C; // 8 data bits
   localparam logic [7:0]  UFT_CTLC_RST  = 8'h00;
   localparam logic [11:0] UFT_BAUD_RST  = 12'h000;
   localparam logic [2:0]  UFT_SIZE_NINE = 3'h7;
   localparam logic [3:0]  UFT_OVS_NORM  = 4'hF; // 16 divider periods per bit
   localparam logic [3:0]  UFT_OVS_DBL   = 4'h7; // 8 in double speed
   // ==========================================================
   // Types
   typedef enum logic [2:0] {
      UFT_IDLE  = 3'b000,
      UFT_START = 3'b001,
      UFT_DATA  = 3'b011,
      UFT_PAR   = 3'b010,
      UFT_STOP  = 3'b110
   } uft_state_t;

   typedef struct packed {
      logic [2:0]  size;
      logic [1:0]  parity;
      logic        stop2;
      logic        dbl;
      logic        sync;
      logic [11:0] baud;
   } uft_cfg_t;

   typedef struct packed {
      logic       ninth;
      logic [7:0] low;
   } uft_char_t;
endpackage : uft_pkg

// >>> hw/uft_transmitter.sv
// Purpose: Transmit path of a serial USART with one character buffer
// Assumes: Inputs synchronous to clock; 20 MHz clock, period 50 ns
// Notes:   Registers on a plain port, read data one cycle after strobe
//
// Overview of operation
// RULE_01: A write to the data buffer location loads it and starts sending. The code needs UFT_CB_TXEN to start from idle; frame-end reload does not.
// RULE_02: Buffer moves to shifter when idle or right after the last stop.
// RULE_03: Bit pace from baud divider and double speed, or external clock.
// RULE_04: Below eight data bits, upper written bits are dropped.
// RULE_05: Host writes only while the buffer-empty flag is set.
// RULE_06: Buffer-empty interrupt handler writes the next character.
// RULE_07: Size code 7 sends the ninth bit, set before the low byte write.
// RULE_08: The ninth bit goes out unchanged for address or sync marking.
// RULE_09: Frame: low start, data LSB first, parity, one or two high stops.
// RULE_10: Parity is XOR of data bits, inverted for odd parity.
// RULE_11: Buffer-empty flag set while no pending character; write clears.
// RULE_12: Complete flag set at frame end with empty buffer; ack or 1 clears.
// RULE_13: Ninth bit is captured with the low byte at write time.
`timescale 1ns/1ps
`default_nettype none
module uft_transmitter
   import uft_pkg::*;
(
   input  wire logic       clock,
   input  wire logic       arst_n,
   input  wire logic [3:0] reg_addr,
   input  wire logic [7:0] reg_wdata,
   input  wire logic       reg_wr,
   input  wire logic       reg_rd,
   output logic      [7:0] reg_rdata,
   input  wire logic       done_irq_ack,
   input  wire logic       external_xfer_clock,
   output logic            txd,
   output logic            txd_oe,
   output logic            irq
);
   // ==========================================================
   // Decoding helpers
   // Data bits carried by a size code
   function automatic logic [3:0] char_bits(input logic [2:0] code);
      char_bits = (code == UFT_SIZE_NINE) ? 4'h9 : {2'b01, code[1:0]} + 4'h1;
   endfunction : char_bits

   // Keep only the low data bits of a character
   function automatic logic [8:0] char_mask(input logic [8:0] d,
                                            input logic [2:0] code);
      logic [8:0] m;
      m = 9'h1FF >> (4'h9 - char_bits(code));
      char_mask = d & m;
   endfunction : char_mask

   // ==========================================================
   // State
   logic [7:0]  ctlb_ff, nxt_ctlb;
   logic [7:0]  ctlc_ff, nxt_ctlc;
   logic [11:0] baud_ff, nxt_baud;
   logic [8:0]  buf_ff, nxt_buf;
   logic        full_ff, nxt_full;
   logic        done_ff, nxt_done;
   logic [1:0]  irqst_ff, nxt_irqst;
   logic [1:0]  irqen_ff, nxt_irqen;
   logic [7:0]  rdata_ff, nxt_rdata;
   logic        irq_ff, nxt_irq;
   uft_state_t  st_ff, nxt_st;
   logic [8:0]  shift_ff, nxt_shift;
   logic [3:0]  bitn_ff, nxt_bitn;
   logic        par_ff, nxt_par;
   logic        stopn_ff, nxt_stopn;
   logic        txd_ff, nxt_txd;
   logic        oe_ff, nxt_oe;
   logic [11:0] pre_ff, nxt_pre;
   logic [3:0]  ovs_ff, nxt_ovs;
   logic        xprv_ff;
   uft_cfg_t    cfg;
   logic        tick;
   logic        load;
   logic        frame_end;
   logic        wr_data;
   uft_char_t   wchar;

   assign cfg = '{size:   ctlb_ff[UFT_CB_SIZE +: 3],
                  parity: ctlc_ff[UFT_CC_PAR +: 2],
                  stop2:  ctlc_ff[UFT_CC_STOP2],
                  dbl:    ctlc_ff[UFT_CC_DBL],
                  sync:   ctlc_ff[UFT_CC_SYNC],
                  baud:   baud_ff};
   assign wr_data = reg_wr && (reg_addr == UFT_ADDR_DATA);
   // Ninth bit taken from control at the moment of the low byte write
   assign wchar = '{ninth: ctlb_ff[UFT_CB_NINTH], low: reg_wdata}; // RULE_13

   // ==========================================================
   // Bit pacing
   // Async: (baud+1) x 16 or x 8 clocks per bit; sync: rising external edge
   always_comb begin
      nxt_pre = pre_ff;
      nxt_ovs = ovs_ff;
      tick    = 1'b0;
      if (cfg.sync) begin
         tick = external_xfer_clock && !xprv_ff; // RULE_03
      end else if (load && st_ff == UFT_IDLE) begin
         // Restart the divider so the start bit gets its full length
         nxt_pre = 12'h000;
         nxt_ovs = 4'h0;
      end else if (pre_ff == cfg.baud) begin
         nxt_pre = 12'h000;
         nxt_ovs = ovs_ff + 4'h1;
         if (ovs_ff == (cfg.dbl ? UFT_OVS_DBL : UFT_OVS_NORM)) begin
            nxt_ovs = 4'h0;
            tick    = 1'b1; // RULE_03
         end
      end else begin
         nxt_pre = pre_ff + 12'h001;
      end
   end

   // ==========================================================
   // Frame sequencer
   // Leaving the last stop bit; a buffered char reloads in the same edge
   assign frame_end = tick && st_ff == UFT_STOP &&
                      (stopn_ff || !cfg.stop2);
   assign load = full_ff && ((st_ff == UFT_IDLE && ctlb_ff[UFT_CB_TXEN])
                 || frame_end); // RULE_02

   always_comb begin
      nxt_st    = st_ff;
      nxt_shift = shift_ff;
      nxt_bitn  = bitn_ff;
      nxt_par   = par_ff;
      nxt_stopn = stopn_ff;
      nxt_txd   = txd_ff;
      if (load) begin
         nxt_st    = UFT_START;
         nxt_shift = char_mask(buf_ff, cfg.size); // RULE_04 RULE_08
         nxt_par   = (^char_mask(buf_ff, cfg.size)) ^ cfg.parity[0]; // RULE_10
         nxt_bitn  = 4'h0;
         nxt_stopn = 1'b0;
         nxt_txd   = 1'b0; // RULE_09
      end else if (tick) begin
         case (st_ff)
            UFT_START: begin
               nxt_st  = UFT_DATA;
               nxt_txd = shift_ff[0]; // RULE_09
            end
            UFT_DATA: begin
               if (bitn_ff == char_bits(cfg.size) - 4'h1) begin
                  nxt_st  = cfg.parity[1] ? UFT_PAR : UFT_STOP;
                  nxt_txd = cfg.parity[1] ? par_ff : 1'b1;
               end else begin
                  nxt_txd   = shift_ff[1];
                  nxt_shift = {1'b0, shift_ff[8:1]};
                  nxt_bitn  = bitn_ff + 4'h1;
               end
            end
            UFT_PAR: begin
               nxt_st  = UFT_STOP;
               nxt_txd = 1'b1;
            end
            UFT_STOP: begin
               nxt_stopn = 1'b1;
               if (frame_end) begin
                  nxt_st = UFT_IDLE; // Line idles high
               end
            end
            default: begin
               nxt_txd = 1'b1;
            end
         endcase
      end
   end

   // ==========================================================
   // Registers, flags and interrupt
   always_comb begin
      nxt_ctlb  = ctlb_ff;
      nxt_ctlc  = ctlc_ff;
      nxt_baud  = baud_ff;
      nxt_buf   = buf_ff;
      nxt_full  = full_ff;
      nxt_done  = done_ff;
      nxt_irqst = irqst_ff;
      nxt_irqen = irqen_ff;
      nxt_rdata = 8'h00;
      if (load) begin
         nxt_full = 1'b0; // RULE_11
      end
      if (wr_data) begin
         nxt_buf  = char_mask(wchar, cfg.size); // RULE_01 RULE_04 RULE_07
         nxt_full = 1'b1; // RULE_11
      end
      // Clears first, so that a same-cycle set still wins
      if (done_irq_ack ||
          (reg_wr && reg_addr == UFT_ADDR_STAT && reg_wdata[UFT_ST_DONE])) begin
         nxt_done = 1'b0; // RULE_12
      end
      if (reg_wr && reg_addr == UFT_ADDR_IRQCLR) begin
         nxt_irqst = irqst_ff & ~reg_wdata[1:0];
      end
      if (frame_end && !full_ff) begin
         nxt_done = 1'b1; // RULE_12
         nxt_irqst[UFT_IRQ_DONE] = 1'b1;
      end
      if (load) begin
         nxt_irqst[UFT_IRQ_EMPTY] = 1'b1;
      end
      if (reg_wr) begin
         case (reg_addr)
            UFT_ADDR_CTLB:  nxt_ctlb = reg_wdata;
            UFT_ADDR_CTLC:  nxt_ctlc = reg_wdata;
            UFT_ADDR_BAUDL: nxt_baud[7:0] = reg_wdata;
            UFT_ADDR_BAUDH: nxt_baud[11:8] = reg_wdata[3:0];
            UFT_ADDR_IRQEN: nxt_irqen = reg_wdata[1:0];
            default: ;
         endcase
      end
      if (reg_rd) begin
         case (reg_addr)
            UFT_ADDR_STAT: begin
               nxt_rdata[UFT_ST_EMPTY] = !full_ff; // RULE_11
               nxt_rdata[UFT_ST_DONE]  = done_ff;
               nxt_rdata[UFT_ST_BUSY]  = st_ff != UFT_IDLE;
            end
            UFT_ADDR_CTLB:  nxt_rdata = ctlb_ff;
            UFT_ADDR_CTLC:  nxt_rdata = ctlc_ff;
            UFT_ADDR_BAUDL: nxt_rdata = baud_ff[7:0];
            UFT_ADDR_BAUDH: nxt_rdata = {4'h0, baud_ff[11:8]};
            UFT_ADDR_IRQST: nxt_rdata = {6'h00, irqst_ff};
            UFT_ADDR_IRQEN: nxt_rdata = {6'h00, irqen_ff};
            default:        nxt_rdata = 8'h00;
         endcase
      end
      nxt_irq = |(nxt_irqst & nxt_irqen);
      // Pin stays claimed until pending and ongoing frames are out
      nxt_oe  = nxt_ctlb[UFT_CB_TXEN] || nxt_full || (nxt_st != UFT_IDLE);
   end

   // Only registering below
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         ctlb_ff  <= UFT_CTLB_RST;
         ctlc_ff  <= UFT_CTLC_RST;
         baud_ff  <= UFT_BAUD_RST;
         buf_ff   <= 9'h000;
         full_ff  <= 1'b0;
         done_ff  <= 1'b0;
         irqst_ff <= 2'h0;
         irqen_ff <= 2'h0;
         rdata_ff <= 8'h00;
         irq_ff   <= 1'b0;
         st_ff    <= UFT_IDLE;
         shift_ff <= 9'h000;
         bitn_ff  <= 4'h0;
         par_ff   <= 1'b0;
         stopn_ff <= 1'b0;
         txd_ff   <= 1'b1;
         oe_ff    <= 1'b0;
         pre_ff   <= 12'h000;
         ovs_ff   <= 4'h0;
         xprv_ff  <= 1'b0;
      end else begin
         ctlb_ff  <= nxt_ctlb;
         ctlc_ff  <= nxt_ctlc;
         baud_ff  <= nxt_baud;
         buf_ff   <= nxt_buf;
         full_ff  <= nxt_full;
         done_ff  <= nxt_done;
         irqst_ff <= nxt_irqst;
         irqen_ff <= nxt_irqen;
         rdata_ff <= nxt_rdata;
         irq_ff   <= nxt_irq;
         st_ff    <= nxt_st;
         shift_ff <= nxt_shift;
         bitn_ff  <= nxt_bitn;
         par_ff   <= nxt_par;
         stopn_ff <= nxt_stopn;
         txd_ff   <= nxt_txd;
         oe_ff    <= nxt_oe;
         pre_ff   <= nxt_pre;
         ovs_ff   <= nxt_ovs;
         xprv_ff  <= external_xfer_clock;
      end
   end

   assign reg_rdata = rdata_ff;
   assign txd       = txd_ff;
   assign txd_oe    = oe_ff;
   assign irq       = irq_ff;
endmodule : uft_transmitter
`default_nettype wire

// >>> testbench/tb.sv
// Purpose: Self-checking bench for the frame transmitter
// Assumes: Baud divider left at 0; transfer clock of 20 cycles
// Notes:   Random formats from a fixed xorshift seed
`timescale 1ns/1ps
`default_nettype none
module tb;
   import uft_pkg::*;
   logic       clock, arst_n, reg_wr, reg_rd, done_irq_ack;
   logic       external_xfer_clock, txd, txd_oe, irq, rx_par, rx_stop;
   logic [3:0] reg_addr;
   logic [7:0] reg_wdata, reg_rdata, d;
   logic [8:0] rx_data, ex;
   logic [2:0] sz;
   logic [31:0] s, r;
   int         err_count, checked, cyc, nbits, par_en, nstop, sync, i;
   int         rx_cnt;
   realtime    t_prev, t_last;
   uft_transmitter dut_u (.clock, .arst_n, .reg_addr, .reg_wdata, .reg_wr,
      .reg_rd, .reg_rdata, .done_irq_ack, .external_xfer_clock, .txd,
      .txd_oe, .irq);
   uft_rx_model rx_u (.clock, .xclk(external_xfer_clock), .txd, .cyc,
      .nbits, .par_en, .nstop, .sync, .rx_data, .rx_par, .rx_stop,
      .rx_cnt, .t_prev, .t_last);
   // ==========================================================
   // Clocks; transfer clock toggles only in the sync section
   initial begin
      clock = 1'b0;
      forever #25 clock = ~clock;
   end
   initial forever begin
      repeat (10) @(posedge clock);
      if (sync != 0) external_xfer_clock <= ~external_xfer_clock;
   end
   function automatic logic [31:0] rnd();
      s ^= s << 13;
      s ^= s >> 17;
      s ^= s << 5;
      return s;
   endfunction : rnd
   // ==========================================================
   // Compare, bus cycles, bounded frame wait, verdict
   task automatic chk(input string n, input logic [8:0] e,
                      input logic [8:0] g);
      checked++;
      if (g !== e) begin
         err_count++;
         $display("unexpected %s: expected %h, seen %h", n, e, g);
      end
   endtask : chk
   task automatic wr(input logic [3:0] a, input logic [7:0] v);
      @(posedge clock);
      reg_addr <= a;
      reg_wdata <= v;
      reg_wr <= 1'b1;
      @(posedge clock);
      reg_wr <= 1'b0;
   endtask : wr
   task automatic rd(input logic [3:0] a);
      @(posedge clock);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clock);
      reg_rd <= 1'b0;
      #1 d = reg_rdata;
   endtask : rd
   task automatic end_of_test();
      $display("mismatches %0d, comparisons %0d", err_count, checked);
      if (err_count == 0 && checked > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask : end_of_test
   task automatic wait_frames(input int n);
      int k;
      k = rx_cnt + n;
      for (int t = 0; rx_cnt < k; t++) begin
         if (t == 20000) begin
            err_count++;
            end_of_test();
         end
         @(posedge clock);
      end
      repeat (310) @(posedge clock);
   endtask : wait_frames
   // ==========================================================
   // Main sequence
   initial begin
      s = 32'h000147BF;
      {arst_n, reg_wr, reg_rd, done_irq_ack, external_xfer_clock} = '0;
      {reg_addr, reg_wdata, err_count, checked, sync} = '0;
      {cyc, nbits, par_en, nstop} = {32'd16, 32'd8, 32'd0, 32'd1};
      repeat (6) @(posedge clock);
      arst_n <= 1'b1;
      rd(UFT_ADDR_STAT);
      chk("status", 9'h001, {1'b0, d});
      rd(UFT_ADDR_CTLB);
      chk("control", 9'h00C, {1'b0, d});
      rd(4'hF);
      chk("unmapped", 9'h000, {1'b0, d});
      repeat (210) @(posedge clock);
      // Random formats; data written while disabled, then ninth bit flipped
      for (i = 0; i < 14; i++) begin
         r = rnd();
         sz = r[2] ? UFT_SIZE_NINE : {1'b0, r[1:0]};
         nbits = r[2] ? 9 : 5 + r[1:0];
         {par_en, nstop, cyc} = {32'(r[7]), 32'(1 + r[8]), r[9] ? 8 : 16};
         wr(UFT_ADDR_CTLC, {4'h0, r[9], r[8], r[7] ? r[7:6] : 2'b00});
         wr(UFT_ADDR_CTLB, {3'h0, sz, r[10], 1'b0});
         wr(UFT_ADDR_DATA, r[23:16]);
         wr(UFT_ADDR_CTLB, {3'h0, sz, ~r[10], 1'b1});
         ex = {r[10], r[23:16]} & ~(9'h1FF << nbits);
         wait_frames(1);
         chk("data", ex, rx_data);
         if (par_en != 0)
            chk("parity", {8'h00, ^ex ^ r[6]}, {8'h00, rx_par});
         chk("stop", 9'h001, {8'h00, rx_stop});
         chk("irq", 9'h000, {8'h00, irq});
      end
      // Second character written once the buffer frees: no gap
      {cyc, nbits, par_en, nstop} = {32'd16, 32'd8, 32'd0, 32'd1};
      wr(UFT_ADDR_CTLC, 8'h00);
      wr(UFT_ADDR_CTLB, 8'h0D);
      wr(UFT_ADDR_DATA, 8'h3C);
      d = 8'h00;
      for (i = 0; i < 100 && !d[UFT_ST_EMPTY]; i++) rd(UFT_ADDR_STAT);
      chk("empty", 9'h001, {8'h00, d[UFT_ST_EMPTY]});
      chk("busy", 9'h001, {8'h00, d[UFT_ST_BUSY]});
      wr(UFT_ADDR_DATA, 8'hC3);
      wait_frames(2);
      chk("data", 9'h0C3, rx_data);
      chk("spacing", 9'h0A0, 9'($rtoi((t_last - t_prev) / 50.0)));
      rd(UFT_ADDR_STAT);
      chk("status", 9'h003, {1'b0, d});
      wr(UFT_ADDR_STAT, 8'h02);
      rd(UFT_ADDR_STAT);
      chk("status", 9'h001, {1'b0, d});
      // Complete interrupt: raise, acknowledge, clear
      wr(UFT_ADDR_IRQCLR, 8'h03);
      wr(UFT_ADDR_IRQEN, 8'h02);
      wr(UFT_ADDR_DATA, 8'h81);
      wait_frames(1);
      rd(UFT_ADDR_IRQST);
      chk("irq status", 9'h003, {1'b0, d});
      chk("irq", 9'h001, {8'h00, irq});
      @(posedge clock);
      done_irq_ack <= 1'b1;
      @(posedge clock);
      done_irq_ack <= 1'b0;
      rd(UFT_ADDR_STAT);
      chk("status", 9'h001, {1'b0, d});
      // Buffer-empty interrupt: the handler supplies the next character
      wr(UFT_ADDR_IRQCLR, 8'h03);
      wr(UFT_ADDR_IRQEN, 8'h01);
      wr(UFT_ADDR_DATA, 8'h5A);
      for (i = 0; i < 20 && !irq; i++) @(posedge clock);
      chk("irq", 9'h001, {8'h00, irq});
      wr(UFT_ADDR_IRQCLR, 8'h01);
      wr(UFT_ADDR_DATA, 8'h96);
      wait_frames(2);
      chk("data", 9'h096, rx_data);
      wr(UFT_ADDR_CTLB, 8'h0C);
      wr(UFT_ADDR_IRQCLR, 8'hFF);
      rd(UFT_ADDR_IRQST);
      chk("irq status", 9'h000, {1'b0, d});
      chk("irq", 9'h000, {8'h00, irq});
      wr(UFT_ADDR_IRQEN, 8'h00);
      // Synchronous mode paced by the transfer clock
      {sync, cyc} = {32'd1, 32'd20};
      wr(UFT_ADDR_CTLC, 8'h10);
      wr(UFT_ADDR_CTLB, 8'h0D);
      // Align to a rising transfer clock edge, bounded in both phases
      for (i = 0; i < 30 && external_xfer_clock; i++) @(posedge clock);
      for (i = 0; i < 30 && !external_xfer_clock; i++) @(posedge clock);
      chk("transfer clock", 9'h001, {8'h00, external_xfer_clock});
      wr(UFT_ADDR_DATA, 8'hA5);
      wait_frames(1);
      chk("data", 9'h0A5, rx_data);
      end_of_test();
   end
endmodule : tb
bind uft_transmitter uft_assertions chk_u (.clock, .arst_n, .reg_addr,
   .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .done_irq_ack,
   .external_xfer_clock, .txd, .txd_oe, .irq);
`default_nettype wire

// >>> testbench/uft_assertions.sv
// Purpose: Port checks for the frame transmitter
// Assumes: Baud divider 0 in async modes, slow transfer clock
// Notes:   Helper flags mirror host writes seen on the port
`timescale 1ns/1ps
`default_nettype none
module uft_assertions
   import uft_pkg::*;
(
   input wire logic       clock,
   input wire logic       arst_n,
   input wire logic [3:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic       reg_wr,
   input wire logic       reg_rd,
   input wire logic [7:0] reg_rdata,
   input wire logic       done_irq_ack,
   input wire logic       external_xfer_clock,
   input wire logic       txd,
   input wire logic       txd_oe,
   input wire logic       irq
);
   logic       en_ff;
   logic       sync_ff;
   logic [7:0] ien_ff;
   logic [8:0] hi_ff;
   wire        wr_dat = reg_wr && reg_addr == UFT_ADDR_DATA;
   wire        wr_clr = reg_wr && reg_addr == UFT_ADDR_IRQCLR;
   // ==========================================================
   // Host settings mirror; high run saturates, marks a quiet line
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         en_ff   <= 1'b0;
         sync_ff <= 1'b0;
         ien_ff  <= 8'h00;
         hi_ff   <= 9'h000;
      end else begin
         if (reg_wr && reg_addr == UFT_ADDR_CTLB) en_ff <= reg_wdata[0];
         if (reg_wr && reg_addr == UFT_ADDR_CTLC) sync_ff <= reg_wdata[4];
         if (reg_wr && reg_addr == UFT_ADDR_IRQEN) ien_ff <= reg_wdata;
         hi_ff <= !txd ? 9'h000 : hi_ff + {8'h00, hi_ff != 9'h1FF};
      end
   end
   default clocking @(posedge clock); endclocking
   default disable iff (!arst_n);
   // ==========================================================
   // Line and timing
   idle_line_a: assert property (!txd_oe |-> txd)
      else $error("line low while released");
   start_len_a: assert property ($fell(txd) |-> !txd [*8])
      else $error("start bit too short");
   bit_hold_a: assert property ($changed(txd) |=> $stable(txd) [*7])
      else $error("bit shorter than eight cycles");
   oe_frame_a: assert property ($fell(txd) |-> txd_oe [*8])
      else $error("pin released inside a frame");
   load_start_a: assert property (wr_dat && en_ff && !sync_ff
      && hi_ff > 9'h0C8 |-> ##2 !txd)
      else $error("no start bit after write on quiet line");
   // Register port and interrupt level
   rd_zero_a: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
      else $error("read data outside answer cycle");
   irq_mask_a: assert property (irq |-> ien_ff[1:0] != 2'h0)
      else $error("interrupt with nothing enabled");
   clr_quiet_a: assert property (wr_clr && reg_wdata == 8'hFF
      && !txd_oe |-> ##2 !irq)
      else $error("interrupt stays after clear");
   cover property (wr_dat && en_ff);
   cover property ($rose(irq));
   cover property (done_irq_ack && irq);
endmodule : uft_assertions
`default_nettype wire

// >>> testbench/uft_rx_model.sv
// Purpose: Remote serial receiver decoding the transmit line
// Assumes: Async bits of cyc clocks; sync bits sampled on transfer clock fall
// Notes:   Listens only, so it never drives the shared line
`timescale 1ns/1ps
`default_nettype none
module uft_rx_model (
   input  wire logic       clock,
   input  wire logic       xclk,
   input  wire logic       txd,
   input  var  int         cyc,
   input  var  int         nbits,
   input  var  int         par_en,
   input  var  int         nstop,
   input  var  int         sync,
   output logic      [8:0] rx_data,
   output logic            rx_par,
   output logic            rx_stop,
   output var  int         rx_cnt,
   output var  realtime    t_prev,
   output var  realtime    t_last
);
   // Sync mode samples mid-bit, opposite the sending edge
   task automatic step(input int n);
      if (sync != 0) @(negedge xclk);
      else repeat (n) @(posedge clock);
   endtask : step
   // ==========================================================
   // Frame decoder: start, data LSB first, parity, stops
   initial begin
      rx_cnt = 0;
      t_last = 0.0;
      forever begin
         @(negedge txd);
         t_prev = t_last;
         t_last = $realtime;
         rx_data = 9'h000;
         step(cyc / 2);
         for (int i = 0; i < nbits; i++) begin
            step(cyc);
            rx_data[i] = txd;
         end
         if (par_en != 0) begin
            step(cyc);
            rx_par = txd;
         end
         rx_stop = 1'b1;
         for (int i = 0; i < nstop; i++) begin
            step(cyc);
            rx_stop &= txd;
         end
         rx_cnt++;
      end
   end
endmodule : uft_rx_model
`default_nettype wire
